// ### channel_result_consts.vh
`ifndef CHANNEL_RESULT_CONSTS_VH
`define CHANNEL_RESULT_CONSTS_VH

// ----------------------------------------------------------------
// Register pointers
// ----------------------------------------------------------------
`define PTR_CHANNEL1_RESULT          8'h02
`define PTR_CHANNEL2_RESULT          8'h04
`define PTR_CHANNEL3_RESULT          8'h06
`define PTR_CHANNEL0_INTERVAL_COUNT  8'h08
`define PTR_CHANNEL1_INTERVAL_COUNT  8'h09
`define PTR_CHANNEL2_INTERVAL_COUNT  8'h0A

// ----------------------------------------------------------------
// Result word layout
// ----------------------------------------------------------------
`define RESULT_MSB                   11
`define RESULT_LSB                   0
`define FLAG_UNDERRANGE_BIT          15
`define FLAG_OVERRANGE_BIT           14
`define FLAG_TIMEOUT_BIT             13
`define FLAG_AMPLITUDE_BIT           12
`define FLAGS_MSB                    15
`define FLAGS_LSB                    12

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define RESULT_RESET                 12'h000
`define FLAGS_RESET                  4'h0
`define INTERVAL_COUNT_RESET         16'h0080
`define INTERVAL_SCALE_SHIFT         4
`define UNMAPPED_READ_VALUE          16'h0000

// ----------------------------------------------------------------
// Serial link
// ----------------------------------------------------------------
`define LINK_ADDR_UPPER              6'h15
`define LINK_BITS_PER_BYTE           4'h8

`endif

// ### channel_result_monitor.sv
`timescale 1ns/1ps
module channel_result_monitor (
    // Clock and reset
    input wire       ref_clk,
    input wire       reset,
    // Link pins
    input wire       scl,
    input wire       sda_in,
    input wire       sda_out,
    input wire       sda_oe,
    // Conversion timing
    input wire [3:0] conversion_end
);
    // ------------------------------------------------
    // Helper counters
    // ------------------------------------------------
    logic [15:0] gap [4];
    logic [3:0]  seen;
    logic [7:0]  low_cnt;

    // Cycles since last end per channel, cycles of SCL low
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            seen    <= 4'h0;
            low_cnt <= 8'h00;
            for (int i = 0; i < 4; i++) begin
                gap[i] <= 16'h0000;
            end
        end else begin
            low_cnt <= scl ? 8'h00 : low_cnt + 8'h01;
            for (int i = 0; i < 4; i++) begin
                gap[i] <= conversion_end[i] ? 16'h0000 : gap[i] + 16'h0001;
                seen[i] <= seen[i] | conversion_end[i];
            end
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    property p_sda_out_low;
        sda_out == 1'b0;
    endproperty
    a_sda_out_low: assert property (p_sda_out_low) else $error("sda_out high");
    property p_oe_moves;
        $changed(sda_oe) |-> !scl && (low_cnt inside {[1:5]});
    endproperty
    a_oe_moves: assert property (p_oe_moves) else $error("sda_oe moved off SCL fall");
    property p_idle_stop;
        scl && $rose(sda_in) |-> !sda_oe [*4];
    endproperty
    a_idle_stop: assert property (p_idle_stop) else $error("sda_oe after stop");
    property p_quiet_reset;
        $fell(reset) |-> !sda_oe [*3];
    endproperty
    a_quiet_reset: assert property (p_quiet_reset) else $error("sda_oe after reset");
    property p_end_pulse;
        conversion_end != 4'h0 |=> (conversion_end & $past(conversion_end)) == 4'h0;
    endproperty
    a_end_pulse: assert property (p_end_pulse) else $error("end pulse too long");
    property p_ch3_period;
        conversion_end[3] && seen[3] |-> gap[3] == 16'd2047;
    endproperty
    a_ch3_period: assert property (p_ch3_period) else $error("ch3 interval wrong");
    property p_ch3_max_gap;
        gap[3] <= 16'd2050;
    endproperty
    a_ch3_max_gap: assert property (p_ch3_max_gap) else $error("ch3 end missing");
    property p_ch0_min_gap;
        conversion_end[0] && seen[0] |-> gap[0] >= 16'd79;
    endproperty
    a_ch0_min_gap: assert property (p_ch0_min_gap) else $error("ch0 end too early");

    c_ch1_period: cover property (conversion_end[1] && seen[1]);
    c_oe_rise: cover property ($rose(sda_oe));
    c_stop: cover property (scl && $rose(sda_in));
endmodule // channel_result_monitor

bind channel_result_regs channel_result_monitor channel_result_monitor_inst (
    .ref_clk(ref_clk), .reset(reset), .scl(scl), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .conversion_end(conversion_end));

// ### channel_result_regs.v
// Function
// (R1) Each result register holds the 12-bit result in 11:0 and the under-range, over-range, timeout and amplitude flags in bits 15 to 12.
// (R2) Each flag stays set until a read returns it, and that read clears it.
// (R3) Result and flags are read-only and read zero after reset.
// (R4) Each channel has a 16-bit read/write interval count that resets to 0x0080; here channel 3 has no register and runs at a fixed 0x0080.
// (R5) The host writes interval counts only from 0x0005 upward; lower codes are reserved.
// (R6) A conversion lasts the interval count times sixteen reference clock cycles.
// (R7) Channel 2 and 3 result registers exist only on the four-channel variant.
// (R8) Result registers sit at even pointers two apart, interval counts consecutively from 0x08.
// (R9) Registers are 16 bits wide, moved as two bytes of one serial transaction.
// (R10) The amplitude flag is raised on an unsettled amplitude only while its reporting is enabled.
// (R11) One read returns flags and result of the same finished conversion.
`timescale 1ns/1ps
`include "channel_result_consts.vh"

module channel_result_regs #(
    parameter FOUR_CHANNEL = 1
) (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        reset,
    // Serial link pins
    input  wire        scl,
    input  wire        sda_in,
    output wire        sda_out,
    output wire        sda_oe,
    input  wire        addr_select,
    // Conversion core, channels 1 to 3 packed low to high
    input  wire [35:0] core_result,
    input  wire [2:0]  underrange_event,
    input  wire [2:0]  overrange_event,
    input  wire [2:0]  timeout_event,
    input  wire [2:0]  amplitude_unsettled,
    input  wire        amplitude_report_enable,
    // Conversion timing, channels 0 to 3
    output wire [3:0]  conversion_end
);

    localparam PH_IDLE    = 3'h0;
    localparam PH_RX      = 3'h1;
    localparam PH_ACK_OUT = 3'h2;
    localparam PH_TX      = 3'h3;
    localparam PH_ACK_IN  = 3'h4;

    reg  [1:0]  scl_sync;
    reg  [1:0]  sda_sync;
    reg  [1:0]  addr_sync;
    reg         scl_prev;
    reg         sda_prev;
    reg  [2:0]  phase;
    reg  [3:0]  bit_cnt;
    reg  [1:0]  byte_idx;
    reg  [7:0]  shift;
    reg  [7:0]  pointer;
    reg  [7:0]  wr_msb;
    reg  [15:0] rd_word;
    reg         reading;
    reg         second_sent;
    reg         host_ack;
    reg  [15:0] interval0;
    reg  [15:0] interval1;
    reg  [15:0] interval2;
    reg  [15:0] sel_word;
    reg  [11:0] clear_vec;
    wire [15:0] word1;
    wire [15:0] word2;
    wire [15:0] word3;
    wire        scl_rise;
    wire        scl_fall;
    wire        start_cond;
    wire        stop_cond;
    wire [7:0]  rx_byte;
    wire        take_read;
    wire [2:0]  amp_flag;
    wire [6:0]  own_addr;

    // ----------------------------------------------------------------
    // Pin synchronisers and edge detect
    // ----------------------------------------------------------------
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            scl_sync  <= 2'b11;
            sda_sync  <= 2'b11;
            addr_sync <= 2'b00;
            scl_prev  <= 1'b1;
            sda_prev  <= 1'b1;
        end else begin
            scl_sync  <= {scl_sync[0], scl};
            sda_sync  <= {sda_sync[0], sda_in};
            addr_sync <= {addr_sync[0], addr_select};
            scl_prev  <= scl_sync[1];
            sda_prev  <= sda_sync[1];
        end
    end

    assign scl_rise   = scl_sync[1] & ~scl_prev;
    assign scl_fall   = ~scl_sync[1] & scl_prev;
    assign start_cond = scl_sync[1] & scl_prev & sda_prev & ~sda_sync[1];
    assign stop_cond  = scl_sync[1] & scl_prev & ~sda_prev & sda_sync[1];
    assign rx_byte    = shift;
    assign own_addr   = {`LINK_ADDR_UPPER, addr_sync[1]};

    // Byte complete with address match and read bit
    assign take_read = (phase == PH_RX) && scl_fall && (bit_cnt == `LINK_BITS_PER_BYTE)
                       && (byte_idx == 2'd0) && (rx_byte[7:1] == own_addr) && rx_byte[0];

    // ----------------------------------------------------------------
    // Channel slots
    // ----------------------------------------------------------------
    // (R10) amplitude flag gating
    assign amp_flag = amplitude_unsettled & {3{amplitude_report_enable}};

    // Channel 0 only paces conversions; its result lives elsewhere
    channel_slot u_slot0 (
        .ref_clk        (ref_clk),
        .reset          (reset),
        .interval_count (interval0),
        .sample_result  (12'h000),
        .sample_flags   (4'h0),
        .flag_clear     (4'h0),
        .result_word    (),
        .conversion_end (conversion_end[0])
    );

    channel_slot u_slot1 (
        .ref_clk        (ref_clk),
        .reset          (reset),
        .interval_count (interval1),
        .sample_result  (core_result[11:0]),
        .sample_flags   ({underrange_event[0], overrange_event[0], timeout_event[0], amp_flag[0]}),
        .flag_clear     (clear_vec[3:0]),
        .result_word    (word1),
        .conversion_end (conversion_end[1])
    );
    channel_slot u_slot2 (
        .ref_clk        (ref_clk),
        .reset          (reset),
        .interval_count (interval2),
        .sample_result  (core_result[23:12]),
        .sample_flags   ({underrange_event[1], overrange_event[1], timeout_event[1], amp_flag[1]}),
        .flag_clear     (clear_vec[7:4]),
        .result_word    (word2),
        .conversion_end (conversion_end[2])
    );
    // Channel 3 count register is outside this block; fixed default
    channel_slot u_slot3 (
        .ref_clk        (ref_clk),
        .reset          (reset),
        .interval_count (`INTERVAL_COUNT_RESET),
        .sample_result  (core_result[35:24]),
        .sample_flags   ({underrange_event[2], overrange_event[2], timeout_event[2], amp_flag[2]}),
        .flag_clear     (clear_vec[11:8]),
        .result_word    (word3),
        .conversion_end (conversion_end[3])
    );

    // ----------------------------------------------------------------
    // Read decode and flag clear
    // ----------------------------------------------------------------
    // (R8) pointer decode
    // (R7) four-channel only registers
    always @* begin
        sel_word  = `UNMAPPED_READ_VALUE;
        clear_vec = 12'h000;
        case (pointer)
            `PTR_CHANNEL1_RESULT:         sel_word = word1;
            `PTR_CHANNEL2_RESULT:
                sel_word = (FOUR_CHANNEL != 0) ? word2 : `UNMAPPED_READ_VALUE;
            `PTR_CHANNEL3_RESULT:
                sel_word = (FOUR_CHANNEL != 0) ? word3 : `UNMAPPED_READ_VALUE;
            `PTR_CHANNEL0_INTERVAL_COUNT: sel_word = interval0;
            `PTR_CHANNEL1_INTERVAL_COUNT: sel_word = interval1;
            `PTR_CHANNEL2_INTERVAL_COUNT:
                sel_word = (FOUR_CHANNEL != 0) ? interval2 : `UNMAPPED_READ_VALUE;
            default: sel_word = `UNMAPPED_READ_VALUE;
        endcase
        // (R2) clear exactly the flags returned
        if (take_read) begin
            case (pointer)
                `PTR_CHANNEL1_RESULT: clear_vec[3:0]  = word1[`FLAGS_MSB:`FLAGS_LSB];
                `PTR_CHANNEL2_RESULT: clear_vec[7:4]  = sel_word[`FLAGS_MSB:`FLAGS_LSB];
                `PTR_CHANNEL3_RESULT: clear_vec[11:8] = sel_word[`FLAGS_MSB:`FLAGS_LSB];
                default:              clear_vec       = 12'h000;
            endcase
        end
    end

    // Open drain: only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe  = (phase == PH_ACK_OUT) || ((phase == PH_TX) && ~shift[7]);

    // ----------------------------------------------------------------
    // Serial link engine
    // ----------------------------------------------------------------
    // (R9) two bytes per register in one transaction
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            phase       <= PH_IDLE;
            bit_cnt     <= 4'h0;
            byte_idx    <= 2'd0;
            shift       <= 8'hFF;
            pointer     <= 8'h00;
            wr_msb      <= 8'h00;
            rd_word     <= 16'h0000;
            reading     <= 1'b0;
            second_sent <= 1'b0;
            host_ack    <= 1'b0;
            // (R4) interval count reset
            interval0   <= `INTERVAL_COUNT_RESET;
            interval1   <= `INTERVAL_COUNT_RESET;
            interval2   <= `INTERVAL_COUNT_RESET;
        end else if (start_cond) begin
            phase    <= PH_RX;
            bit_cnt  <= 4'h0;
            byte_idx <= 2'd0;
            shift    <= 8'hFF;
        end else if (stop_cond) begin
            phase <= PH_IDLE;
            shift <= 8'hFF;
        end else begin
            case (phase)
                PH_RX: begin
                    if (scl_rise) begin
                        shift   <= {shift[6:0], sda_sync[1]};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && (bit_cnt == `LINK_BITS_PER_BYTE)) begin
                        phase <= PH_ACK_OUT;
                        shift <= 8'hFF;
                        if (byte_idx == 2'd0) begin
                            reading <= rx_byte[0];
                            if (rx_byte[7:1] != own_addr) begin
                                phase <= PH_IDLE;
                            end else if (rx_byte[0]) begin
                                // (R11) whole word snapshot
                                rd_word <= sel_word;
                            end
                        end else if (byte_idx == 2'd1) begin
                            pointer <= rx_byte;
                        end else if (byte_idx == 2'd2) begin
                            wr_msb <= rx_byte;
                        end else begin
                            // (R3) result registers ignore writes
                            case (pointer)
                                `PTR_CHANNEL0_INTERVAL_COUNT: interval0 <= {wr_msb, rx_byte};
                                `PTR_CHANNEL1_INTERVAL_COUNT: interval1 <= {wr_msb, rx_byte};
                                `PTR_CHANNEL2_INTERVAL_COUNT:
                                    interval2 <= (FOUR_CHANNEL != 0) ? {wr_msb, rx_byte}
                                                                     : interval2;
                                default: pointer <= pointer;
                            endcase
                        end
                        if (byte_idx != 2'd3) begin
                            byte_idx <= byte_idx + 2'd1;
                        end
                    end
                end
                PH_ACK_OUT: begin
                    if (scl_fall) begin
                        bit_cnt <= 4'h0;
                        if (reading) begin
                            phase       <= PH_TX;
                            shift       <= rd_word[15:8];
                            second_sent <= 1'b0;
                        end else begin
                            phase <= PH_RX;
                        end
                    end
                end
                PH_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt == 4'h7) begin
                            phase <= PH_ACK_IN;
                            shift <= 8'hFF;
                        end else begin
                            shift   <= {shift[6:0], 1'b1};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                end
                PH_ACK_IN: begin
                    if (scl_rise) begin
                        host_ack <= ~sda_sync[1];
                    end else if (scl_fall) begin
                        bit_cnt <= 4'h0;
                        if (host_ack && !second_sent) begin
                            phase       <= PH_TX;
                            shift       <= rd_word[7:0];
                            second_sent <= 1'b1;
                        end else begin
                            phase <= PH_IDLE;
                        end
                    end
                end
                default: phase <= PH_IDLE;
            endcase
        end
    end

endmodule // channel_result_regs

// ### channel_slot.v
`timescale 1ns/1ps
`include "channel_result_consts.vh"

module channel_slot (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        reset,
    // Configuration
    input  wire [15:0] interval_count,
    // Conversion core samples
    input  wire [11:0] sample_result,
    input  wire [3:0]  sample_flags,
    // Read side
    input  wire [3:0]  flag_clear,
    output wire [15:0] result_word,
    output reg         conversion_end
);

    reg  [19:0] elapsed;
    reg  [11:0] result;
    reg  [3:0]  flags;
    wire [19:0] period;
    wire        wrap;
    wire [3:0]  next_flags;

    // Interval is count times sixteen reference cycles
    // (R6) interval timer length
    assign period = {interval_count, {`INTERVAL_SCALE_SHIFT{1'b0}}};
    assign wrap   = (elapsed >= (period - 20'h00001));

    // Sticky flags, a new event beats a clear in the same cycle
    // (R2) clear on read
    assign next_flags = (flags & ~flag_clear) | (wrap ? sample_flags : 4'h0);

    // (R1) packed word layout
    assign result_word = {flags, result};

    // ----------------------------------------------------------------
    // Conversion timer and result capture
    // ----------------------------------------------------------------
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            elapsed        <= 20'h00000;
            conversion_end <= 1'b0;
            result         <= `RESULT_RESET;
            flags          <= `FLAGS_RESET;
        end else begin
            conversion_end <= wrap;
            flags          <= next_flags;
            if (wrap) begin
                elapsed <= 20'h00000;
                // (R11) word updates whole
                result  <= sample_result;
            end else begin
                elapsed <= elapsed + 20'h00001;
            end
        end
    end

endmodule // channel_slot

// ### inductive_link_host.sv
`timescale 1ns/1ps
module inductive_link_host (
    // Link pins
    output logic scl,
    output logic sda_low,
    input  wire  sda
);
    // Idle bus, clock stands high
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    // ------------------------------------------------
    // Bit and frame tasks, 48 ns link period
    // ------------------------------------------------
    // nine bits MSB first
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            sda_low = !tx[i];
            #12 scl = 1'b1;
            #12 rx[i] = sda;
            #12 scl = 1'b0;
            #12;
        end
    endtask
    // Start or repeated start
    task automatic start();
        sda_low = 1'b0;
        #12 scl = 1'b1;
        #12 sda_low = 1'b1;
        #12 scl = 1'b0;
        #12;
    endtask
    // Stop, then clock stands still
    task automatic stop();
        sda_low = 1'b1;
        #12 scl = 1'b1;
        #12 sda_low = 1'b0;
        #24;
    endtask
    task automatic write_word(input logic [6:0] a, input logic [7:0] p,
                              input logic [15:0] d, output logic ok);
        logic [7:0] b [4];
        logic [8:0] r;
        b  = '{{a, 1'b0}, p, d[15:8], d[7:0]};
        ok = 1'b1;
        start();
        foreach (b[i]) begin
            xfer({b[i], 1'b1}, r);
            ok &= !r[0];
        end
        stop();
    endtask
    // repeated start, ACK MSB, NACK LSB
    task automatic read_word(input logic [6:0] a, input logic [7:0] p,
                             output logic [15:0] d, output logic ok);
        logic [8:0] r [5];
        start();
        xfer({a, 1'b0, 1'b1}, r[0]);
        xfer({p, 1'b1}, r[1]);
        start();
        xfer({a, 1'b1, 1'b1}, r[2]);
        xfer(9'h1FE, r[3]);
        xfer(9'h1FF, r[4]);
        stop();
        d  = {r[3][8:1], r[4][8:1]};
        ok = !(r[0][0] | r[1][0] | r[2][0]);
    endtask
endmodule // inductive_link_host

// ### tb_top.sv
`timescale 1ns/1ps
`include "channel_result_consts.vh"
module tb_top;
    logic        ref_clk;
    logic        reset;
    logic [35:0] core_result;
    logic [2:0]  underrange_event;
    logic [2:0]  overrange_event;
    logic [2:0]  timeout_event;
    logic [2:0]  amplitude_unsettled;
    logic        amplitude_report_enable;
    wire         scl;
    wire         sda_low;
    wire         sda;
    wire         oe_four;
    wire         oe_two;
    wire  [3:0]  conversion_end;
    int          failures;
    int          samples_checked;
    int          n;
    logic [15:0] rd;
    logic        ok;
    logic [6:0]  lo = {`LINK_ADDR_UPPER, 1'b0};
    logic [6:0]  hi = {`LINK_ADDR_UPPER, 1'b1};
    logic [7:0]  ptr [6] = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h09, 8'h0A};
    logic [15:0] wv [3] = '{16'h00A5, 16'h0005, 16'h0006};
    logic [15:0] fa [3] = '{16'h8ABC, 16'h4123, 16'h2FED};
    int          per [3] = '{80, 96, 2048};

    // Open-drain data line with pull-up
    assign sda = !(sda_low | oe_four | oe_two);
    // Clock
    always #2 ref_clk = !ref_clk;

    inductive_link_host host_inst (.scl(scl), .sda_low(sda_low), .sda(sda));
    channel_result_regs #(.FOUR_CHANNEL(1)) channel_result_regs_inst (
        .ref_clk(ref_clk), .reset(reset), .scl(scl), .sda_in(sda), .sda_out(),
        .sda_oe(oe_four), .addr_select(1'b0), .core_result(core_result),
        .underrange_event(underrange_event), .overrange_event(overrange_event),
        .timeout_event(timeout_event), .amplitude_unsettled(amplitude_unsettled),
        .amplitude_report_enable(amplitude_report_enable),
        .conversion_end(conversion_end));
    channel_result_regs #(.FOUR_CHANNEL(0)) channel_result_regs_two_inst (
        .ref_clk(ref_clk), .reset(reset), .scl(scl), .sda_in(sda), .sda_out(),
        .sda_oe(oe_two), .addr_select(1'b1), .core_result(core_result),
        .underrange_event(underrange_event), .overrange_event(overrange_event),
        .timeout_event(timeout_event), .amplitude_unsettled(amplitude_unsettled),
        .amplitude_report_enable(amplitude_report_enable), .conversion_end());

    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] p, input logic [15:0] e);
        host_inst.read_word(a, p, rd, ok);
        check("read ack", 16'h0001, {15'h0000, ok});
        check($sformatf("pointer %h", p), e, rd);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d);
        host_inst.write_word(a, p, d, ok);
        check("write ack", 16'h0001, {15'h0000, ok});
    endtask
    task automatic wait_end(input int idx);
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (conversion_end[idx] !== 1'b1 && n < 5000);
        if (n >= 5000) begin
            failures++;
            conclude();
        end
    endtask
    task automatic conclude();
        if (failures == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        ref_clk = 1'b0;
        reset = 1'b1;
        core_result = {12'hFED, 12'h123, 12'hABC};
        {underrange_event, overrange_event, timeout_event} = 9'h000;
        amplitude_unsettled = 3'h0;
        amplitude_report_enable = 1'b0;
        failures = 0;
        samples_checked = 0;
        repeat (10) @(posedge ref_clk);
        #1 reset = 1'b0;
        repeat (5) @(posedge ref_clk);
        #1;
        for (int i = 0; i < 6; i++) begin
            rd_chk(lo, ptr[i], i < 3 ? 16'h0000 : `INTERVAL_COUNT_RESET);
        end
        rd_chk(lo, 8'h0B, `UNMAPPED_READ_VALUE);
        wr(lo, ptr[0], 16'h5555);
        rd_chk(lo, ptr[0], {4'h0, core_result[11:0]});
        for (int i = 0; i < 3; i++) begin
            wr(lo, ptr[i + 3], wv[i]);
            rd_chk(lo, ptr[i + 3], wv[i]);
        end
        for (int i = 0; i < 3; i++) begin
            wait_end(i + 1);
            wait_end(i + 1);
            check("conversion period", per[i][15:0], n[15:0]);
        end
        // Errors per channel, amplitude reporting off
        @(posedge ref_clk);
        #1 {underrange_event, overrange_event, timeout_event} = 9'b001_010_100;
        amplitude_unsettled = 3'h7;
        wait_end(3);
        {underrange_event, overrange_event, timeout_event} = 9'h000;
        amplitude_unsettled = 3'h0;
        for (int i = 0; i < 3; i++) begin
            rd_chk(lo, ptr[i], fa[i]);
            rd_chk(lo, ptr[i], {4'h0, fa[i][11:0]});
        end
        // Amplitude reporting on, channel 2 only
        amplitude_report_enable = 1'b1;
        amplitude_unsettled = 3'h2;
        wait_end(3);
        amplitude_unsettled = 3'h0;
        rd_chk(lo, ptr[1], 16'h1123);
        rd_chk(lo, ptr[0], 16'h0ABC);
        // Two-channel variant
        rd_chk(hi, ptr[0], 16'h8ABC);
        wr(hi, ptr[5], 16'h0007);
        rd_chk(hi, ptr[1], 16'h0000);
        rd_chk(hi, ptr[2], 16'h0000);
        rd_chk(hi, ptr[5], 16'h0000);
        rd_chk(hi, ptr[3], `INTERVAL_COUNT_RESET);
        conclude();
    end
endmodule // tb_top
